/* common/flash_cmd_regs.vh */
// Command codes, unlock addresses and bus timing for the flash command host
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
`define CMD_UNLOCK1      8'hAA
`define CMD_UNLOCK2      8'h55
`define CMD_AUTOSEL      8'h90
`define CMD_SECURE_ENT   8'h88
`define CMD_EXIT_DATA    8'h00
`define CMD_PROG         8'hA0
`define CMD_BYPASS       8'h20
`define CMD_RESET        8'hF0
`define CMD_SUSPEND      8'hB0
`define CMD_RESUME       8'h30
`define ADDR_U1_WORD     20'h0_0555
`define ADDR_U2_WORD     20'h0_02AA
`define ADDR_U1_BYTE     20'h0_0AAA
`define ADDR_U2_BYTE     20'h0_0555
`define ADDR_PROT_WORD   20'h0_0002
`define ADDR_PROT_BYTE   20'h0_0004
`define ADDR_ANY         20'h0_0000
`define SECT_MASK        20'hF_F000
`define POLL_BIT         7
`define TOGGLE_BIT       6
`define SECT_TOGGLE_BIT  2
`define T_WE_LOW_NS      35
`define T_WE_HIGH_NS     30
`define T_RD_NS          90
`define CLK_NS           40
`define SUSPEND_MAX_US   35
`define CYC_WE_LOW  (((`T_WE_LOW_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define CYC_WE_HIGH (((`T_WE_HIGH_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define CYC_RD      (((`T_RD_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define CYC_SUSPEND (((`SUSPEND_MAX_US) * 1000 + (`CLK_NS) - 1) / (`CLK_NS))
`endif

/* rtl/flash_bus_cycle.v */
// One write or read cycle on the flash pins, timed in clock cycles
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"
module flash_bus_cycle (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        start,
  input  wire        is_write,
  input  wire [19:0] addr,
  input  wire [15:0] wdata,
  input  wire [15:0] dq_sync,
  output reg  [19:0] fl_addr_q,
  output reg  [15:0] dq_out_q,
  output reg         dq_oe_q,
  output reg         we_n_q,
  output reg         oe_n_q,
  output reg         ce_n_q,
  output reg  [15:0] rdata_q,
  output reg         done_q
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_ACT  = 2'd1;
  localparam [1:0] S_HOLD = 2'd2;
  localparam [1:0] S_SAMP = 2'd3;
  localparam integer WE_LOW_I  = `CYC_WE_LOW;
  localparam integer WE_HIGH_I = `CYC_WE_HIGH;
  localparam integer RD_I      = `CYC_RD + 2;
  reg [1:0] state_q;
  reg [3:0] cnt_q;
  reg       wr_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= S_IDLE;
      cnt_q     <= 4'h0;
      wr_q      <= 1'b0;
      fl_addr_q <= 20'h0_0000;
      dq_out_q  <= 16'h0000;
      dq_oe_q   <= 1'b0;
      we_n_q    <= 1'b1;
      oe_n_q    <= 1'b1;
      ce_n_q    <= 1'b1;
      rdata_q   <= 16'h0000;
      done_q    <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        S_IDLE: if (start) begin
          fl_addr_q <= addr;
          dq_out_q  <= wdata;
          dq_oe_q   <= is_write;
          wr_q      <= is_write;
          ce_n_q    <= 1'b0;
          we_n_q    <= ~is_write;
          oe_n_q    <= is_write;
          // Read waits extra for the two-stage input synchroniser
          cnt_q     <= is_write ? WE_LOW_I[3:0] : RD_I[3:0];
          state_q   <= S_ACT;
        end
        S_ACT: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else if (wr_q) begin
            we_n_q  <= 1'b1;
            cnt_q   <= WE_HIGH_I[3:0];
            state_q <= S_HOLD;
          end else begin
            state_q <= S_SAMP;
          end
        end
        S_SAMP: begin
          rdata_q <= dq_sync;
          oe_n_q  <= 1'b1;
          ce_n_q  <= 1'b1;
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        S_HOLD: begin
          ce_n_q  <= 1'b1;
          dq_oe_q <= 1'b0;
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            done_q  <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // flash_bus_cycle

/* rtl/flash_erase_suspend_cmd_decoder.v */
// Host-side command sequencer for a parallel NOR flash: suspend, resume, autoselect, bypass
// Functional notes
// - Suspend is one write of B0, address ignored.
// - Host tells erasing from suspended by poll bit high with toggle bit 6 steady.
// - Resume is one write of 30 at any address.
// - Autoselect is AA, 55, 90; protect read at offset 02 word, 04 byte.
// - Protected-area entry is AA, 55, 88; exit is AA, 55, 90, 00.
// - Bypass program is A0 then program address with program data.
// - Bypass exit is 90 then 00 at any address.
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"
module flash_erase_suspend_cmd_decoder (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire [3:0]  op,
  input  wire        op_valid,
  input  wire [19:0] op_addr,
  input  wire [15:0] op_data,
  input  wire        byte_mode,
  input  wire [15:0] dq_in,
  output reg         op_ready_q,
  output reg         op_done_q,
  output reg  [15:0] op_rdata_q,
  output reg         erase_active_q,
  output reg         suspended_q,
  output reg         sector_protected_q,
  output reg  [19:0] fl_addr_q,
  output reg  [15:0] dq_out_q,
  output reg         dq_oe_q,
  output reg         we_n_q,
  output reg         oe_n_q,
  output reg         ce_n_q
);
  // User operation codes
  localparam [3:0] OP_SUSPEND   = 4'd0;
  localparam [3:0] OP_RESUME    = 4'd1;
  localparam [3:0] OP_AUTOSEL   = 4'd2;
  localparam [3:0] OP_PROT_VFY  = 4'd3;
  localparam [3:0] OP_SEC_ENTER = 4'd4;
  localparam [3:0] OP_SEC_EXIT  = 4'd5;
  localparam [3:0] OP_BYP_PROG  = 4'd6;
  localparam [3:0] OP_BYP_EXIT  = 4'd7;
  localparam [3:0] OP_RESET     = 4'd8;
  localparam [3:0] OP_READ      = 4'd9;
  localparam [3:0] OP_WRITE     = 4'd10;
  localparam [3:0] OP_POLL      = 4'd11;
  localparam [3:0] OP_ERASE_ON  = 4'd12;
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_RUN  = 2'd1;
  localparam [1:0] S_WAIT = 2'd2;
  localparam [1:0] S_FIN  = 2'd3;
  localparam integer SUSP_CYC = `CYC_SUSPEND;
  reg        rst_m_q;
  reg        rst_n_q;
  reg [15:0] dq_m_q;
  reg [15:0] dq_s_q;
  reg [1:0]  state_q;
  reg [3:0]  op_q;
  reg [19:0] addr_q;
  reg [15:0] data_q;
  reg        bm_q;
  reg [2:0]  step_q;
  reg [2:0]  nsteps_q;
  reg [15:0] wait_q;
  reg [15:0] prev_q;
  reg        have_prev_q;
  reg        start;
  reg        is_write;
  reg [19:0] cyc_addr;
  reg [15:0] cyc_data;
  wire [15:0] bc_rdata;
  wire        bc_done;
  wire [19:0] bc_addr;
  wire [15:0] bc_dout;
  wire        bc_oe;
  wire        bc_we_n;
  wire        bc_oe_n;
  wire        bc_ce_n;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end
  always @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end else begin
      dq_m_q <= dq_in;
      dq_s_q <= dq_m_q;
    end
  end
  // Address and data of each bus step
  always @* begin
    is_write = 1'b1;
    cyc_addr = `ADDR_ANY;
    cyc_data = 16'h0000;
    if ((op_q == OP_AUTOSEL) || (op_q == OP_PROT_VFY) ||
        (op_q == OP_SEC_ENTER) || (op_q == OP_SEC_EXIT)) begin
      case (step_q)
        3'd0: begin
          cyc_addr = bm_q ? `ADDR_U1_BYTE : `ADDR_U1_WORD;
          cyc_data = {8'h00, `CMD_UNLOCK1};
        end
        3'd1: begin
          cyc_addr = bm_q ? `ADDR_U2_BYTE : `ADDR_U2_WORD;
          cyc_data = {8'h00, `CMD_UNLOCK2};
        end
        3'd2: begin
          cyc_addr = bm_q ? `ADDR_U1_BYTE : `ADDR_U1_WORD;
          cyc_data = {8'h00, (op_q == OP_SEC_ENTER) ? `CMD_SECURE_ENT : `CMD_AUTOSEL};
        end
        default: begin
          if (op_q == OP_SEC_EXIT) begin
            cyc_data = {8'h00, `CMD_EXIT_DATA};
          end else if (op_q == OP_PROT_VFY) begin
            is_write = 1'b0;
            cyc_addr = (addr_q & `SECT_MASK) |
                       (bm_q ? `ADDR_PROT_BYTE : `ADDR_PROT_WORD);
          end else begin
            is_write = 1'b0;
            cyc_addr = addr_q;
          end
        end
      endcase
    end else begin
      case (op_q)
        OP_SUSPEND: cyc_data = {8'h00, `CMD_SUSPEND};
        OP_RESUME:  cyc_data = {8'h00, `CMD_RESUME};
        OP_RESET:   cyc_data = {8'h00, `CMD_RESET};
        OP_BYP_PROG: begin
          cyc_data = (step_q == 3'd0) ? {8'h00, `CMD_PROG} : data_q;
          cyc_addr = (step_q == 3'd0) ? `ADDR_ANY : addr_q;
        end
        OP_BYP_EXIT: cyc_data = {8'h00, (step_q == 3'd0) ? `CMD_AUTOSEL : `CMD_EXIT_DATA};
        OP_WRITE: begin
          cyc_addr = addr_q;
          cyc_data = data_q;
        end
        default: begin
          is_write = 1'b0;
          cyc_addr = addr_q;
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q            <= S_IDLE;
      op_q               <= OP_RESET;
      addr_q             <= 20'h0_0000;
      data_q             <= 16'h0000;
      bm_q               <= 1'b0;
      step_q             <= 3'd0;
      nsteps_q           <= 3'd1;
      wait_q             <= 16'h0000;
      prev_q             <= 16'h0000;
      have_prev_q        <= 1'b0;
      start              <= 1'b0;
      op_ready_q         <= 1'b0;
      op_done_q          <= 1'b0;
      op_rdata_q         <= 16'h0000;
      erase_active_q     <= 1'b0;
      suspended_q        <= 1'b0;
      sector_protected_q <= 1'b0;
    end else begin
      start     <= 1'b0;
      op_done_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          op_ready_q <= 1'b1;
          if (op_valid && op_ready_q) begin
            op_ready_q <= 1'b0;
            op_q       <= op;
            addr_q     <= op_addr;
            data_q     <= op_data;
            bm_q       <= byte_mode;
            step_q     <= 3'd0;
            case (op)
              OP_AUTOSEL, OP_PROT_VFY, OP_SEC_EXIT: nsteps_q <= 3'd4;
              OP_SEC_ENTER:             nsteps_q <= 3'd3;
              OP_BYP_PROG, OP_BYP_EXIT: nsteps_q <= 3'd2;
              default:                  nsteps_q <= 3'd1;
            endcase
            if (op == OP_ERASE_ON) begin
              erase_active_q <= 1'b1;
              state_q        <= S_FIN;
            end else if ((op == OP_SUSPEND && !erase_active_q) ||
                         (op == OP_RESUME && !suspended_q)) begin
              // Not sent: suspend needs a running sector erase, resume a suspension
              state_q <= S_FIN;
            end else begin
              start   <= 1'b1;
              state_q <= S_RUN;
            end
          end
        end
        S_RUN: if (bc_done) begin
          if (!is_write) begin
            op_rdata_q <= bc_rdata;
          end
          if (op_q == OP_PROT_VFY) begin
            sector_protected_q <= bc_rdata[0];
          end
          if (step_q + 3'd1 < nsteps_q) begin
            step_q <= step_q + 3'd1;
            start  <= 1'b1;
          end else if (op_q == OP_SUSPEND) begin
            wait_q      <= SUSP_CYC[15:0];
            have_prev_q <= 1'b0;
            state_q     <= S_WAIT;
          end else begin
            if (op_q == OP_RESUME) begin
              suspended_q <= 1'b0;
            end
            if (op_q == OP_RESET && !suspended_q) begin
              erase_active_q <= 1'b0;
            end
            state_q <= S_FIN;
          end
        end
        S_WAIT: begin
          // Poll bit high and toggle bit still means suspension reached
          if (!start && (bc_done || !have_prev_q)) begin
            if (bc_done) begin
              op_rdata_q  <= bc_rdata;
              prev_q      <= bc_rdata;
              have_prev_q <= 1'b1;
            end
            if (bc_done && have_prev_q && bc_rdata[`POLL_BIT] &&
                (bc_rdata[`TOGGLE_BIT] == prev_q[`TOGGLE_BIT])) begin
              suspended_q <= 1'b1;
              state_q     <= S_FIN;
            end else if (wait_q == 16'h0000) begin
              state_q <= S_FIN;
            end else begin
              start  <= 1'b1;
              op_q   <= OP_POLL;
            end
          end
          if (wait_q != 16'h0000) begin
            wait_q <= wait_q - 16'h0001;
          end
        end
        S_FIN: begin
          op_done_q <= 1'b1;
          state_q   <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  flash_bus_cycle u_bus (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_q),
    .start     (start),
    .is_write  (is_write),
    .addr      (cyc_addr),
    .wdata     (cyc_data),
    .dq_sync   (dq_s_q),
    .fl_addr_q (bc_addr),
    .dq_out_q  (bc_dout),
    .dq_oe_q   (bc_oe),
    .we_n_q    (bc_we_n),
    .oe_n_q    (bc_oe_n),
    .ce_n_q    (bc_ce_n),
    .rdata_q   (bc_rdata),
    .done_q    (bc_done)
  );

  // Pins taken from the bus engine's registers
  always @* begin
    fl_addr_q = bc_addr;
    dq_out_q  = bc_dout;
    dq_oe_q   = bc_oe;
    we_n_q    = bc_we_n;
    oe_n_q    = bc_oe_n;
    ce_n_q    = bc_ce_n;
  end
endmodule // flash_erase_suspend_cmd_decoder

/* test/flash_dev_model.sv */
// Behavioural flash device driven by the host's pins
`timescale 1ns/100ps
`include "flash_cmd_regs.vh"
module flash_dev_model #(
  parameter SUSP_DLY = 20,
  parameter LOAD_DLY = 50,
  parameter [7:0] ERS_SECT = 8'h02
) (
  input  wire        clk_sys,
  input  wire        erase_go,
  input  wire [19:0] fl_addr_q,
  input  wire [15:0] dq_out_q,
  input  wire        we_n_q,
  input  wire        oe_n_q,
  input  wire        ce_n_q,
  output wire [15:0] dq_in
);
  reg         ers_q, susp_q, as_q, tog_q, we_pq, oe_pq;
  reg  [1:0]  ucnt_q;
  reg  [7:0]  h0_q, h1_q;
  reg  [15:0] last_q;
  integer     wcnt, dly, tmo;
  wire        rd  = !oe_n_q && !ce_n_q;
  wire [7:0]  lo  = dq_out_q[7:0];
  wire        prt = fl_addr_q[7:0] == 8'h02 || fl_addr_q[7:0] == 8'h04;
  // Only the sector chosen for erase shows status while suspended
  wire        in_sect = fl_addr_q[19:12] == ERS_SECT;
  wire [15:0] val = as_q ? {15'h0000, prt} :
                    (ers_q || (susp_q && in_sect)) ? {8'h00, susp_q, tog_q, 6'h00} :
                    fl_addr_q[15:0] ^ 16'h5A5A;
  // Released bus shows the inverse of the last value
  assign dq_in = rd ? val : ~last_q;
  initial begin
    {ers_q, susp_q, as_q, tog_q, we_pq, oe_pq} = 6'h3;
    {ucnt_q, h0_q, h1_q, last_q} = 0;
    wcnt = 0;
    dly = 0;
    tmo = 0;
  end
  always @(posedge clk_sys) begin
    we_pq <= we_n_q;
    oe_pq <= oe_n_q;
    if (rd)
      last_q <= val;
    if (oe_n_q && !oe_pq && ers_q)
      tog_q <= !tog_q;
    if (erase_go) begin
      ers_q <= 1'b1;
      tmo <= LOAD_DLY;
    end
    if (tmo > 0)
      tmo <= tmo - 1;
    if (dly > 0)
      dly <= dly - 1;
    if (dly == 1) begin
      ers_q <= 1'b0;
      susp_q <= 1'b1;
    end
    if (we_n_q && !we_pq && !ce_n_q) begin
      wcnt <= wcnt + 1;
      h1_q <= h0_q;
      h0_q <= lo;
      ucnt_q <= lo == `CMD_UNLOCK1 ? 2'd1 : (lo == `CMD_UNLOCK2 && ucnt_q == 1) ? 2'd2 : 2'd0;
      if (lo == `CMD_AUTOSEL && ucnt_q == 2)
        as_q <= 1'b1;
      if (lo == `CMD_RESET || lo == `CMD_EXIT_DATA)
        as_q <= 1'b0;
      if (lo == `CMD_SUSPEND && ers_q && dly == 0) begin
        if (tmo > 0) begin
          ers_q <= 1'b0;
          susp_q <= 1'b1;
          tmo <= 0;
        end else
          dly <= SUSP_DLY;
      end
      if (lo == `CMD_RESUME && susp_q) begin
        susp_q <= 1'b0;
        ers_q <= 1'b1;
      end
    end
  end
endmodule // flash_dev_model

/* test/flash_erase_suspend_cmd_decoder_properties.sv */
// Pin and handshake checks for the flash command host
`timescale 1ns/100ps
module flash_erase_suspend_cmd_decoder_properties (
  input wire       clk_sys,
  input wire       arst_n,
  input wire [3:0] op,
  input wire       op_valid,
  input wire       op_ready_q,
  input wire       op_done_q,
  input wire       erase_active_q,
  input wire       suspended_q,
  input wire       dq_oe_q,
  input wire       we_n_q,
  input wire       oe_n_q,
  input wire       ce_n_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire take = op_valid && op_ready_q;
  a_we_drives_bus: assert property (!we_n_q |-> !ce_n_q && dq_oe_q)
    else $error("write strobe without select or drive");
  a_read_no_drive: assert property (!oe_n_q |-> we_n_q && !dq_oe_q)
    else $error("read overlaps drive or write");
  a_we_one_cycle: assert property ($fell(we_n_q) |=> $rose(we_n_q))
    else $error("write strobe length wrong");
  a_read_hold: assert property ($fell(oe_n_q) |-> !oe_n_q [*3])
    else $error("read strobe too short");
  a_done_pulse: assert property (op_done_q |=> !op_done_q)
    else $error("done longer than one cycle");
  a_take_drops_ready: assert property (take |=> !op_ready_q)
    else $error("ready stayed high after take");
  a_susp_refused: assert property (take && op == 4'h0 && !erase_active_q
    |=> we_n_q throughout (##[0:2] op_done_q))
    else $error("suspend without erase not refused");
  a_resume_refused: assert property (take && op == 4'h1 && !suspended_q
    |=> we_n_q throughout (##[0:2] op_done_q))
    else $error("resume without suspend not refused");
  a_susp_bounded: assert property (take && op == 4'h0 && erase_active_q
    |-> ##[1:1000] op_done_q)
    else $error("suspend wait unbounded");
endmodule // flash_erase_suspend_cmd_decoder_properties

/* test/tb_flash_erase_suspend_cmd_decoder.sv */
// Testbench for the flash command host against a device model
`timescale 1ns/100ps
module tb_flash_erase_suspend_cmd_decoder;
  reg         clk_sys, arst_n, op_valid, byte_mode, erase_go;
  reg  [3:0]  op;
  reg  [19:0] op_addr;
  reg  [15:0] op_data;
  wire [15:0] dq_in, op_rdata_q, dq_out_q;
  wire [19:0] fl_addr_q;
  wire        op_ready_q, op_done_q, erase_active_q, suspended_q, sector_protected_q;
  wire        dq_oe_q, we_n_q, oe_n_q, ce_n_q;
  integer     n_mismatch, total_checks, w0;
  flash_erase_suspend_cmd_decoder u_flash_erase_suspend_cmd_decoder (
    .clk_sys(clk_sys), .arst_n(arst_n), .op(op), .op_valid(op_valid),
    .op_addr(op_addr), .op_data(op_data), .byte_mode(byte_mode), .dq_in(dq_in),
    .op_ready_q(op_ready_q), .op_done_q(op_done_q), .op_rdata_q(op_rdata_q),
    .erase_active_q(erase_active_q), .suspended_q(suspended_q),
    .sector_protected_q(sector_protected_q), .fl_addr_q(fl_addr_q),
    .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .we_n_q(we_n_q), .oe_n_q(oe_n_q),
    .ce_n_q(ce_n_q));
  flash_dev_model u_flash_dev_model (
    .clk_sys(clk_sys), .erase_go(erase_go), .fl_addr_q(fl_addr_q),
    .dq_out_q(dq_out_q), .we_n_q(we_n_q), .oe_n_q(oe_n_q), .ce_n_q(ce_n_q),
    .dq_in(dq_in));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task do_op(input [3:0] o, input [19:0] a, input [15:0] d);
    integer k;
    begin
      k = 0;
      @(negedge clk_sys);
      while (op_ready_q !== 1'b1 && k < 2000) begin
        @(negedge clk_sys);
        k = k + 1;
      end
      op = o;
      op_addr = a;
      op_data = d;
      op_valid = 1'b1;
      @(negedge clk_sys);
      op_valid = 1'b0;
      while (op_done_q !== 1'b1 && k < 2000) begin
        @(negedge clk_sys);
        k = k + 1;
      end
      chk(k < 2000, 16'h0001);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    {arst_n, op_valid, byte_mode, erase_go, op, op_addr, op_data} = 0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(negedge clk_sys);
    arst_n = 1'b1;
    do_op(4'd9, 20'h0_1234, 16'h0000);
    chk(op_rdata_q, 16'h1234 ^ 16'h5A5A);
    do_op(4'd0, 20'h0_0000, 16'h0000);
    chk(suspended_q, 16'h0000);
    w0 = u_flash_dev_model.wcnt;
    do_op(4'd4, 20'h0_0000, 16'h0000);
    chk(u_flash_dev_model.wcnt - w0, 16'h0003);
    chk(u_flash_dev_model.h0_q, 16'h0088);
    w0 = u_flash_dev_model.wcnt;
    do_op(4'd5, 20'h0_0000, 16'h0000);
    chk(u_flash_dev_model.wcnt - w0, 16'h0004);
    chk({u_flash_dev_model.h1_q, u_flash_dev_model.h0_q}, 16'h9000);
    do_op(4'd6, 20'h0_0100, 16'h3C12);
    chk({u_flash_dev_model.h1_q, u_flash_dev_model.h0_q}, 16'hA012);
    do_op(4'd7, 20'h0_0000, 16'h0000);
    chk({u_flash_dev_model.h1_q, u_flash_dev_model.h0_q}, 16'h9000);
    do_op(4'd8, 20'h0_0000, 16'h0000);
    chk(u_flash_dev_model.h0_q, 16'h00F0);
    $display("test commands done");
    erase_go = 1'b1;
    @(negedge clk_sys);
    erase_go = 1'b0;
    do_op(4'd12, 20'h0_0000, 16'h0000);
    do_op(4'd1, 20'h0_0000, 16'h0000);
    chk(suspended_q, 16'h0000);
    do_op(4'd0, 20'h0_2000, 16'h0000);
    chk(suspended_q, 16'h0001);
    chk(u_flash_dev_model.h0_q, 16'h00B0);
    do_op(4'd9, 20'h0_2000, 16'h0000);
    chk(op_rdata_q[7], 16'h0001);
    chk(op_rdata_q[15:8], 16'h0000);
    do_op(4'd9, 20'h0_1234, 16'h0000);
    chk(op_rdata_q, 16'h1234 ^ 16'h5A5A);
    do_op(4'd10, 20'h0_1200, 16'h3355);
    chk(u_flash_dev_model.h0_q, 16'h0055);
    do_op(4'd2, 20'h0_2000, 16'h0000);
    chk(op_rdata_q, 16'h0000);
    do_op(4'd3, 20'h0_3000, 16'h0000);
    chk(sector_protected_q, 16'h0001);
    byte_mode = 1'b1;
    do_op(4'd3, 20'h0_3000, 16'h0000);
    chk(sector_protected_q, 16'h0001);
    byte_mode = 1'b0;
    do_op(4'd8, 20'h0_0000, 16'h0000);
    chk(suspended_q, 16'h0001);
    do_op(4'd1, 20'h1_0000, 16'h0000);
    chk(suspended_q, 16'h0000);
    chk(u_flash_dev_model.ers_q, 16'h0001);
    do_op(4'd0, 20'h0_2000, 16'h0000);
    chk(suspended_q, 16'h0001);
    chk(u_flash_dev_model.susp_q, 16'h0001);
    $display("test suspend done");
    complete_run;
  end
endmodule // tb_flash_erase_suspend_cmd_decoder
bind flash_erase_suspend_cmd_decoder flash_erase_suspend_cmd_decoder_properties u_props (
  .clk_sys, .arst_n, .op, .op_valid, .op_ready_q, .op_done_q, .erase_active_q,
  .suspended_q, .dq_oe_q, .we_n_q, .oe_n_q, .ce_n_q);
